// ### design/cstso_defines.svh
// constants for the store, transfer and stop instruction executor
// How it works
// [RL1] oscillator-stop halts the oscillator; everything stops until external wake-up.
// [RL2] wait gates the internal clock off; oscillator keeps running.
// [RL3] store-X writes index X to the addressed memory location.
// [RL4] store-Y writes index Y to the addressed memory location.
// [RL5] opcode 5B copies accumulator A into the page base register.
// [RL6] accumulator A to stack loads the stack pointer from A.
// [RL7] A copied into X or into Y; Y form is opcode A8.
// [RL8] prefixed 42 form copies accumulator B into the page base register.
// [RL9] prefixed B to stack, two bytes, four cycles, loads stack from B.
// [RL10] prefixed forms copy accumulator B into X or into Y.
// [RL11] page base register copied into accumulator A.
// [RL12] prefixed form copies page base register into accumulator B.
// [RL13] stack pointer copied into A, or B in prefixed form.
// [RL14] stack pointer copied into index X.
// [RL15] index X copied into A, or B in prefixed form.
// [RL16] stack pointer loaded from index X.
// [RL17] opcode 9B copies index X into index Y.
// [RL18] index Y copied into A, or B in prefixed form.
// [RL19] opcode BB copies index Y into index X.
// [RL20] bytes 89 28, six cycles, swap accumulators A and B at once.
`ifndef CSTSO_DEFINES_SVH
`define CSTSO_DEFINES_SVH
`define CSTSO_PREFIX_B    8'h42
`define CSTSO_PREFIX_SWAP 8'h89
`define CSTSO_OP_SWAP     8'h28
`define CSTSO_OP_STOP     8'hDB
`define CSTSO_OP_WAIT     8'hC2
`define CSTSO_OP_STORE_X  8'h86
`define CSTSO_OP_STORE_Y  8'h84
`define CSTSO_OP_A2D      8'h5B
`define CSTSO_OP_A2S      8'h1B
`define CSTSO_OP_A2X      8'hAA
`define CSTSO_OP_A2Y      8'hA8
`define CSTSO_OP_D2A      8'h7B
`define CSTSO_OP_S2A      8'h3B
`define CSTSO_OP_S2X      8'hBA
`define CSTSO_OP_X2A      8'h8A
`define CSTSO_OP_X2S      8'h9A
`define CSTSO_OP_X2Y      8'h9B
`define CSTSO_OP_Y2A      8'h98
`define CSTSO_OP_Y2X      8'hBB
`define CSTSO_CYC_SHORT   4'h2
`define CSTSO_CYC_PREFIX  4'h4
`define CSTSO_CYC_SWAP    4'h6
`define CSTSO_CYC_LOWPWR  4'h3
`define CSTSO_CYC_STORE   4'h4
`define CSTSO_RST_WORD    16'h0000
`endif

// ### design/cstso_pkg.sv
// types for the store, transfer and stop instruction executor
package cstso_pkg;
   typedef enum logic [2:0] {
      CSTSO_IDLE   = 3'b000,
      CSTSO_EXEC   = 3'b001,
      CSTSO_STORE  = 3'b010,
      CSTSO_HALT   = 3'b011,
      CSTSO_GATED  = 3'b100
   } cstso_state_e;

   typedef enum logic [2:0] {
      CSTSO_R_A  = 3'b000,
      CSTSO_R_B  = 3'b001,
      CSTSO_R_X  = 3'b010,
      CSTSO_R_Y  = 3'b011,
      CSTSO_R_S  = 3'b100,
      CSTSO_R_D  = 3'b101,
      CSTSO_R_NO = 3'b111
   } cstso_reg_e;

   // decoded instruction
   typedef struct packed {
      logic       legal;
      cstso_reg_e src;
      cstso_reg_e dst;
      logic       swap;
      logic       store;
      logic       stop;
      logic       wait_op;
      logic [3:0] cycles;
   } cstso_dec_s;

   // programmer visible register set
   typedef struct packed {
      logic [15:0] acc_a;
      logic [15:0] acc_b;
      logic [15:0] idx_x;
      logic [15:0] idx_y;
      logic [15:0] stk;
      logic [15:0] page;
   } cstso_regs_s;

   // memory write request
   typedef struct packed {
      logic        wr;
      logic [23:0] addr;
      logic [15:0] data;
   } cstso_mem_s;
endpackage

// ### design/cstso_decode.sv
// opcode decoder for the store, transfer and stop instructions
`timescale 1ns/100ps
`include "cstso_defines.svh"
module cstso_decode
   import cstso_pkg::*;
(
   input  wire logic [7:0] op_first,
   input  wire logic [7:0] op_second,
   output cstso_dec_s      dec
);
   logic pre_b;
   logic [7:0] op;

   // pick the opcode byte behind a prefix
   always_comb begin
      pre_b = (op_first == `CSTSO_PREFIX_B);
      op    = pre_b ? op_second : op_first;
   end

   // table lookup
   always_comb begin
      dec         = '0;
      dec.src     = CSTSO_R_NO;
      dec.dst     = CSTSO_R_NO;
      dec.legal   = 1'b1;
      dec.cycles  = pre_b ? `CSTSO_CYC_PREFIX : `CSTSO_CYC_SHORT;
      if (op_first == `CSTSO_PREFIX_SWAP) begin
         dec.legal  = (op_second == `CSTSO_OP_SWAP);
         dec.swap   = 1'b1; // RL20
         dec.cycles = `CSTSO_CYC_SWAP;
      end else begin
         case (op)
            `CSTSO_OP_A2D: begin
               dec.src = pre_b ? CSTSO_R_B : CSTSO_R_A; // RL5 RL8
               dec.dst = CSTSO_R_D;
            end
            `CSTSO_OP_A2S: begin
               dec.src = pre_b ? CSTSO_R_B : CSTSO_R_A; // RL6 RL9
               dec.dst = CSTSO_R_S;
            end
            `CSTSO_OP_A2X: begin
               dec.src = pre_b ? CSTSO_R_B : CSTSO_R_A; // RL7 RL10
               dec.dst = CSTSO_R_X;
            end
            `CSTSO_OP_A2Y: begin
               dec.src = pre_b ? CSTSO_R_B : CSTSO_R_A; // RL7 RL10
               dec.dst = CSTSO_R_Y;
            end
            `CSTSO_OP_D2A: begin
               dec.src = CSTSO_R_D;
               dec.dst = pre_b ? CSTSO_R_B : CSTSO_R_A; // RL11 RL12
            end
            `CSTSO_OP_S2A: begin
               dec.src = CSTSO_R_S;
               dec.dst = pre_b ? CSTSO_R_B : CSTSO_R_A; // RL13
            end
            `CSTSO_OP_X2A: begin
               dec.src = CSTSO_R_X;
               dec.dst = pre_b ? CSTSO_R_B : CSTSO_R_A; // RL15
            end
            `CSTSO_OP_Y2A: begin
               dec.src = CSTSO_R_Y;
               dec.dst = pre_b ? CSTSO_R_B : CSTSO_R_A; // RL18
            end
            `CSTSO_OP_S2X: begin
               dec.legal = !pre_b;
               dec.src   = CSTSO_R_S; // RL14
               dec.dst   = CSTSO_R_X;
            end
            `CSTSO_OP_X2S: begin
               dec.legal = !pre_b;
               dec.src   = CSTSO_R_X; // RL16
               dec.dst   = CSTSO_R_S;
            end
            `CSTSO_OP_X2Y: begin
               dec.legal = !pre_b;
               dec.src   = CSTSO_R_X; // RL17
               dec.dst   = CSTSO_R_Y;
            end
            `CSTSO_OP_Y2X: begin
               dec.legal = !pre_b;
               dec.src   = CSTSO_R_Y; // RL19
               dec.dst   = CSTSO_R_X;
            end
            `CSTSO_OP_STORE_X: begin
               dec.legal  = !pre_b;
               dec.src    = CSTSO_R_X; // RL3
               dec.store  = 1'b1;
               dec.cycles = `CSTSO_CYC_STORE;
            end
            `CSTSO_OP_STORE_Y: begin
               dec.legal  = !pre_b;
               dec.src    = CSTSO_R_Y; // RL4
               dec.store  = 1'b1;
               dec.cycles = `CSTSO_CYC_STORE;
            end
            `CSTSO_OP_STOP: begin
               dec.legal  = !pre_b;
               dec.stop   = 1'b1; // RL1
               dec.cycles = `CSTSO_CYC_LOWPWR;
            end
            `CSTSO_OP_WAIT: begin
               dec.legal   = !pre_b;
               dec.wait_op = 1'b1; // RL2
               dec.cycles  = `CSTSO_CYC_LOWPWR;
            end
            default: begin
               dec.legal = 1'b0;
            end
         endcase
      end
   end
endmodule

// ### design/cstso_core.sv
// executor for store, transfer, exchange and low-power instructions
`timescale 1ns/100ps
`include "cstso_defines.svh"
module cstso_core
   import cstso_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        instr_valid,
   input  wire logic [7:0]  instr_first,
   input  wire logic [7:0]  instr_second,
   input  wire logic [23:0] store_addr,
   input  wire logic        wake,
   input  wire logic        regs_load,
   input  cstso_regs_s      regs_init,
   output logic             instr_ready,
   output logic             instr_illegal,
   output cstso_mem_s       mem_req,
   output cstso_regs_s      regs,
   output logic             osc_run,
   output logic             core_clk_en
);
   typedef struct packed {
      cstso_state_e st;
      cstso_regs_s  r;
      cstso_mem_s   mem;
      cstso_dec_s   dec;
      logic [3:0]   cnt;
      logic         illegal;
      logic         osc;
      logic         clk_en;
   } cstso_core_s;

   cstso_core_s q, d;
   cstso_dec_s  dec_now;
   logic [15:0] src_val;

   cstso_decode u_dec (
      .op_first  (instr_first),
      .op_second (instr_second),
      .dec       (dec_now)
   );

   // read the source register of the held instruction
   always_comb begin
      case (q.dec.src)
         CSTSO_R_A: src_val = q.r.acc_a;
         CSTSO_R_B: src_val = q.r.acc_b;
         CSTSO_R_X: src_val = q.r.idx_x;
         CSTSO_R_Y: src_val = q.r.idx_y;
         CSTSO_R_S: src_val = q.r.stk;
         CSTSO_R_D: src_val = q.r.page;
         default:   src_val = `CSTSO_RST_WORD;
      endcase
   end

   // next state
   always_comb begin
      d         = q;
      d.mem.wr  = 1'b0;
      d.illegal = 1'b0;
      case (q.st)
         CSTSO_IDLE: begin
            if (instr_valid) begin
               if (!dec_now.legal) begin
                  d.illegal = 1'b1;
               end else begin
                  d.dec      = dec_now;
                  d.cnt      = dec_now.cycles - 4'h1;
                  d.mem.addr = store_addr;
                  d.st       = CSTSO_EXEC;
               end
            end else if (regs_load) begin
               // words written by the rest of the core, only between
               // instructions so a transfer never sees them change
               d.r = regs_init;
            end
         end
         CSTSO_EXEC: begin
            if (q.cnt > 4'h1) begin
               d.cnt = q.cnt - 4'h1;
            end else begin
               d.st = CSTSO_IDLE;
               if (q.dec.swap) begin
                  d.r.acc_a = q.r.acc_b; // RL20
                  d.r.acc_b = q.r.acc_a; // RL20
               end else if (q.dec.store) begin
                  d.mem.wr   = 1'b1; // RL3 RL4
                  d.mem.data = src_val;
               end else if (q.dec.stop) begin
                  d.osc    = 1'b0; // RL1
                  d.clk_en = 1'b0;
                  d.st     = CSTSO_HALT;
               end else if (q.dec.wait_op) begin
                  d.clk_en = 1'b0; // RL2
                  d.st     = CSTSO_GATED;
               end else begin
                  case (q.dec.dst)
                     CSTSO_R_A: d.r.acc_a = src_val;
                     CSTSO_R_B: d.r.acc_b = src_val;
                     CSTSO_R_X: d.r.idx_x = src_val;
                     CSTSO_R_Y: d.r.idx_y = src_val;
                     CSTSO_R_S: d.r.stk   = src_val;
                     CSTSO_R_D: d.r.page  = src_val;
                     default:   d.r       = q.r;
                  endcase
               end
            end
         end
         CSTSO_HALT, CSTSO_GATED: begin
            if (wake) begin
               d.osc    = 1'b1;
               d.clk_en = 1'b1;
               d.st     = CSTSO_IDLE;
            end
         end
         default: d.st = CSTSO_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         q        <= '0;
         q.st     <= CSTSO_IDLE;
         q.osc    <= 1'b1;
         q.clk_en <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // outputs
   assign instr_ready   = (q.st == CSTSO_IDLE);
   assign instr_illegal = q.illegal;
   assign mem_req       = q.mem;
   assign regs          = q.r;
   assign osc_run       = q.osc;
   assign core_clk_en   = q.clk_en;

   // checks
   a_swap_both: assert property ( // RL20
      @(posedge ref_clk) disable iff (!nrst)
      (q.st == CSTSO_IDLE && instr_valid && instr_first == 8'h89
       && instr_second == 8'h28) |-> ##6
      (q.r.acc_a == $past(q.r.acc_b, 6) && q.r.acc_b == $past(q.r.acc_a, 6)))
      else $error("swap did not exchange accumulators");
   a_swap_time: assert property ( // RL20
      @(posedge ref_clk) disable iff (!nrst)
      (q.st == CSTSO_IDLE && instr_valid && instr_first == 8'h89
       && instr_second == 8'h28) |-> ##1 !instr_ready [*5] ##1 instr_ready)
      else $error("swap length wrong");
   a_stop_osc: assert property ( // RL1
      @(posedge ref_clk) disable iff (!nrst)
      (q.st == CSTSO_EXEC && q.dec.stop && q.cnt == 4'h1) |=> !osc_run
      && !core_clk_en)
      else $error("oscillator not stopped");
   a_halt_hold: assert property ( // RL1
      @(posedge ref_clk) disable iff (!nrst)
      (q.st == CSTSO_HALT && !wake) |=> !osc_run && !instr_ready)
      else $error("halt released without wake");
   a_wait_gate: assert property ( // RL2
      @(posedge ref_clk) disable iff (!nrst)
      (q.st == CSTSO_GATED) |-> osc_run && !core_clk_en)
      else $error("wait state clocking wrong");
   a_store_x: assert property ( // RL3
      @(posedge ref_clk) disable iff (!nrst)
      (q.st == CSTSO_IDLE && instr_valid && instr_first == 8'h86)
      |-> ##4 (mem_req.wr && mem_req.data == $past(q.r.idx_x, 4)))
      else $error("store x wrong");
   a_store_y: assert property ( // RL4
      @(posedge ref_clk) disable iff (!nrst)
      (q.st == CSTSO_IDLE && instr_valid && instr_first == 8'h84)
      |-> ##4 (mem_req.wr && mem_req.data == $past(q.r.idx_y, 4)))
      else $error("store y wrong");
   a_a_to_page: assert property ( // RL5
      @(posedge ref_clk) disable iff (!nrst)
      (q.st == CSTSO_IDLE && instr_valid && instr_first == 8'h5B)
      |-> ##2 (regs.page == $past(q.r.acc_a, 2)))
      else $error("a to page wrong");
   a_b_to_stack: assert property ( // RL9
      @(posedge ref_clk) disable iff (!nrst)
      (q.st == CSTSO_IDLE && instr_valid && instr_first == 8'h42
       && instr_second == 8'h1B)
      |-> ##1 !instr_ready [*3] ##1 (regs.stk == $past(q.r.acc_b, 4)))
      else $error("b to stack wrong");
   a_x_to_y: assert property ( // RL17
      @(posedge ref_clk) disable iff (!nrst)
      (q.st == CSTSO_IDLE && instr_valid && instr_first == 8'h9B)
      |-> ##2 (regs.idx_y == $past(q.r.idx_x, 2)))
      else $error("x to y wrong");
   a_y_to_x: assert property ( // RL19
      @(posedge ref_clk) disable iff (!nrst)
      (q.st == CSTSO_IDLE && instr_valid && instr_first == 8'hBB)
      |-> ##2 (regs.idx_x == $past(q.r.idx_y, 2)))
      else $error("y to x wrong");
endmodule

// ### dv/cpu_store_transfer_stop_ops_tb.sv
// self-checking bench for the store, transfer and low-power executor
`timescale 1ns/100ps
module cpu_store_transfer_stop_ops_tb;
   import cstso_pkg::*;

   logic        ref_clk;
   logic        nrst;
   logic        instr_valid;
   logic [7:0]  instr_first;
   logic [7:0]  instr_second;
   logic [23:0] store_addr;
   logic        wake;
   logic        instr_ready;
   logic        instr_illegal;
   cstso_mem_s  mem_req;
   cstso_regs_s regs;
   logic        osc_run;
   logic        core_clk_en;
   int          mismatches;
   int          n_compared;
   logic        regs_load;
   cstso_regs_s regs_init;

   // distinct words per register, in the field order of the register set
   localparam logic [95:0] init_regs = {16'h1A1A, 16'h2B2B, 16'h3C3C,
                                        16'h4D4D, 16'h5E5E, 16'h6F6F};

   cstso_core i_dut (
      .ref_clk       (ref_clk),
      .nrst          (nrst),
      .instr_valid   (instr_valid),
      .instr_first   (instr_first),
      .instr_second  (instr_second),
      .store_addr    (store_addr),
      .wake          (wake),
      .regs_load     (regs_load),
      .regs_init     (regs_init),
      .instr_ready   (instr_ready),
      .instr_illegal (instr_illegal),
      .mem_req       (mem_req),
      .regs          (regs),
      .osc_run       (osc_run),
      .core_clk_en   (core_clk_en)
   );

   // 25 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // compare one value, count it and report a mismatch
   task automatic chk(input logic [95:0] got, input logic [95:0] exp,
                      input string msg);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %0h exp %0h", $time, msg, got,
                  exp);
      end
   endtask

   // print counts and verdict, then stop
   task automatic give_verdict;
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // present one instruction for the take edge, then withdraw it
   task automatic issue(input logic [7:0] f, input logic [7:0] s);
      @(negedge ref_clk);
      instr_valid  = 1'b1;
      instr_first  = f;
      instr_second = s;
      @(posedge ref_clk);
      @(negedge ref_clk);
      instr_valid  = 1'b0;
   endtask

   // hand the core known register words while it is idle
   task automatic preload;
      @(negedge ref_clk);
      regs_load = 1'b1;
      @(negedge ref_clk);
      regs_load = 1'b0;
   endtask

   // run a transfer and check its latency and register contents;
   // register codes 0..5 follow the field order of the register set
   task automatic run(input logic [7:0] f, input logic [7:0] s,
                      input int cyc, input cstso_reg_e sk,
                      input cstso_reg_e dk);
      int          n;
      logic [95:0] w;
      logic [95:0] e;
      w = init_regs;
      e = init_regs;
      e[95 - 16 * int'(dk) -: 16] = w[95 - 16 * int'(sk) -: 16];
      // the exchange also moves B into A
      if (f == 8'h89) begin
         e[95:80] = w[79:64];
      end
      preload();
      issue(f, s);
      n = 1;
      while (instr_ready !== 1'b1 && n < 20) begin
         @(negedge ref_clk);
         n++;
      end
      chk(96'(n), 96'(cyc), "latency");
      chk(96'(regs), e, "registers");
   endtask

   // reset values of the registers and the status flags
   task automatic t_reset;
      chk(96'(regs), 96'h0, "reset regs");
      chk(96'({instr_ready, osc_run, core_clk_en, mem_req.wr,
               instr_illegal}), 96'h1C, "reset flags");
      $display("test reset done");
   endtask

   // every transfer but Y to X, plain and prefixed, plus the exchange
   task automatic t_transfer;
      run(8'h5B, 8'h00, 2, CSTSO_R_A, CSTSO_R_D);
      run(8'h1B, 8'h00, 2, CSTSO_R_A, CSTSO_R_S);
      run(8'hAA, 8'h00, 2, CSTSO_R_A, CSTSO_R_X);
      run(8'hA8, 8'h00, 2, CSTSO_R_A, CSTSO_R_Y);
      run(8'h7B, 8'h00, 2, CSTSO_R_D, CSTSO_R_A);
      run(8'h3B, 8'h00, 2, CSTSO_R_S, CSTSO_R_A);
      run(8'hBA, 8'h00, 2, CSTSO_R_S, CSTSO_R_X);
      run(8'h8A, 8'h00, 2, CSTSO_R_X, CSTSO_R_A);
      run(8'h9A, 8'h00, 2, CSTSO_R_X, CSTSO_R_S);
      run(8'h9B, 8'h00, 2, CSTSO_R_X, CSTSO_R_Y);
      run(8'h98, 8'h00, 2, CSTSO_R_Y, CSTSO_R_A);
      run(8'h42, 8'h5B, 4, CSTSO_R_B, CSTSO_R_D);
      run(8'h42, 8'h1B, 4, CSTSO_R_B, CSTSO_R_S);
      run(8'h42, 8'hAA, 4, CSTSO_R_B, CSTSO_R_X);
      run(8'h42, 8'hA8, 4, CSTSO_R_B, CSTSO_R_Y);
      run(8'h42, 8'h7B, 4, CSTSO_R_D, CSTSO_R_B);
      run(8'h42, 8'h3B, 4, CSTSO_R_S, CSTSO_R_B);
      run(8'h42, 8'h8A, 4, CSTSO_R_X, CSTSO_R_B);
      run(8'h42, 8'h98, 4, CSTSO_R_Y, CSTSO_R_B);
      run(8'h89, 8'h28, 6, CSTSO_R_A, CSTSO_R_B);
      $display("test transfer done");
   endtask

   // stores of both index registers with distinct addresses
   task automatic t_store(input logic [7:0] op, input logic [23:0] a,
                          input cstso_reg_e k);
      int          n;
      logic [95:0] w;
      logic [15:0] v;
      w = init_regs;
      v = w[95 - 16 * int'(k) -: 16];
      preload();
      store_addr = a;
      issue(op, 8'h00);
      store_addr = ~a;
      n = 1;
      while (mem_req.wr !== 1'b1 && n < 20) begin
         @(negedge ref_clk);
         n++;
      end
      chk(96'(n), 96'h4, "store latency");
      chk(96'(mem_req.addr), 96'(a), "store addr");
      chk(96'(mem_req.data), 96'(v), "store data");
      @(negedge ref_clk);
      chk(96'(mem_req.wr), 96'h0, "store pulse");
      $display("test store %0h done", op);
   endtask

   // stop or wait: core_clk_en falls, osc_run too for stop only, then wake brings them back
   task automatic t_lowpwr(input logic [7:0] op, input logic exp_osc);
      int n;
      issue(op, 8'h00);
      n = 1;
      while (core_clk_en !== 1'b0 && n < 20) begin
         @(negedge ref_clk);
         n++;
      end
      chk(96'(n), 96'h3, "low power latency");
      repeat (4) @(negedge ref_clk);
      chk(96'({osc_run, core_clk_en, instr_ready}), 96'({exp_osc, 2'b00}),
          "asleep");
      wake = 1'b1;
      @(negedge ref_clk);
      wake = 1'b0;
      chk(96'({osc_run, core_clk_en}), 96'h3, "woken");
      @(negedge ref_clk);
      $display("test low power %0h done", op);
   endtask

   // unknown opcode and a prefix before a non-prefixable op
   task automatic t_illegal(input logic [7:0] f, input logic [7:0] s);
      preload();
      issue(f, s);
      chk(96'({instr_illegal, instr_ready}), 96'h3, "illegal pulse");
      @(negedge ref_clk);
      chk(96'(instr_illegal), 96'h0, "illegal end");
      chk(96'(regs), init_regs, "illegal no effect");
      $display("test illegal %0h %0h done", f, s);
   endtask

   // watchdog sized well beyond the sequence length
   initial begin
      #(40 * 5000);
      mismatches++;
      $display("mismatch at %0t: watchdog expired", $time);
      give_verdict();
   end

   // main sequence
   initial begin
      mismatches   = 0;
      n_compared   = 0;
      nrst         = 1'b0;
      instr_valid  = 1'b0;
      instr_first  = 8'h00;
      instr_second = 8'h00;
      store_addr   = 24'h000000;
      wake         = 1'b0;
      regs_load    = 1'b0;
      regs_init    = init_regs;
      repeat (10) @(negedge ref_clk);
      nrst = 1'b1;
      t_reset();
      t_transfer();
      t_store(8'h86, 24'hA5C3F0, CSTSO_R_X);
      t_store(8'h84, 24'h5A3C0F, CSTSO_R_Y);
      t_lowpwr(8'hDB, 1'b0);
      t_lowpwr(8'hC2, 1'b1);
      t_illegal(8'h00, 8'h00);
      t_illegal(8'h42, 8'h9B);
      run(8'hBB, 8'h00, 2, CSTSO_R_Y, CSTSO_R_X);
      // reset again with loaded registers so the reset check has teeth
      @(negedge ref_clk);
      nrst = 1'b0;
      repeat (2) @(negedge ref_clk);
      nrst = 1'b1;
      t_reset();
      give_verdict();
   end
endmodule
